/* hdl/arseq_sequencer.v */
`timescale 1ns/1ps
`default_nettype none
`include "arseq_defines.vh"
// ************************************************
// ************************************************
module arseq_sequencer #(
	parameter TW = `ARSEQ_TW,
	parameter NIN = 15
)(
	input wire pclk,
	input wire presetn,
	input wire clk_en,
	input wire tick,
	input wire [7:0] paddr,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output wire pready,
	output reg pslverr,
	input wire prot_trip_in,
	input wire prot_start_in,
	input wire ext_trip_in,
	input wire ext_start_in,
	input wire sensitive_ground_fault_trip_in,
	input wire breaker_closed_in,
	input wire breaker_in_service_in,
	input wire breaker_energy_ok_in,
	input wire dead_time_start_permit_in,
	input wire dead_time_enable_in,
	input wire delayed_reclose_done_in,
	input wire sync_check_a_in,
	input wire sync_check_b_in,
	input wire system_check_ok_in,
	input wire manual_close_inhibit_in,
	output wire reclose_cycle_active,
	output reg reclose_cycle_active_secondary,
	output reg [2:0] shot_counter,
	output wire [4:0] shot_count_is,
	output reg successful_reclose,
	output wire reclose_enabled_flag,
	output reg inhibit_main_instant_stages,
	output reg inhibit_sensitive_ground_stages,
	output wire reclose_checks,
	output wire dead_time_running,
	output reg dead_time_done,
	output reg synchronism_ok_flag,
	output reg system_checks_pass_flag,
	output reg auto_close,
	output reg protection_lockout,
	output wire reset_lockout_ind,
	output reg voltage_check_fail_alarm,
	output reg breaker_energy_fail_alarm,
	output wire reclose_lockout_alarm
);
	// ************************************************
	// states, one-hot
	// ************************************************
	localparam S_IDLE = 7'b0000001;
	localparam S_PRIME = 7'b0000010;
	localparam S_DEAD = 7'b0000100;
	localparam S_CHECK = 7'b0001000;
	localparam S_CLOSE = 7'b0010000;
	localparam S_RECL = 7'b0100000;
	localparam S_LOCK = 7'b1000000;
	// timer slots
	localparam T_DEAD = 0;
	localparam T_RECL = 1;
	localparam T_SYS = 2;
	localparam T_HLT = 3;

	// ************************************************
	// pin synchronisers
	// ************************************************
	wire [NIN-1:0] pin_w; // raw pins, one bit each
	reg [NIN-1:0] s1_r; // first stage, read by s2 only
	reg [NIN-1:0] s2_r;
	reg [NIN-1:0] s3_r;
	reg [NIN-1:0] flt_r; // accepted level

	assign pin_w = {manual_close_inhibit_in, system_check_ok_in,
		sync_check_b_in, sync_check_a_in, delayed_reclose_done_in,
		dead_time_enable_in, dead_time_start_permit_in,
		breaker_energy_ok_in, breaker_in_service_in, breaker_closed_in,
		sensitive_ground_fault_trip_in, ext_start_in, ext_trip_in,
		prot_start_in, prot_trip_in};

	genvar gi;
	generate
		for (gi = 0; gi < NIN; gi = gi + 1)
		begin : g_sync
			// a change counts only once stages two and three agree
			always @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
				begin
					s1_r[gi] <= 1'b0;
					s2_r[gi] <= 1'b0;
					s3_r[gi] <= 1'b0;
					flt_r[gi] <= 1'b0;
				end
				else if (clk_en)
				begin
					s1_r[gi] <= pin_w[gi];
					s2_r[gi] <= s1_r[gi];
					s3_r[gi] <= s2_r[gi];
					if (s2_r[gi] == s3_r[gi])
						flt_r[gi] <= s3_r[gi];
				end
			end
		end
	endgenerate

	// named views of the filtered pins
	wire p_trip = flt_r[0];
	wire p_start = flt_r[1];
	wire x_trip = flt_r[2];
	wire x_start = flt_r[3];
	wire sg_trip = flt_r[4];
	wire brk_closed = flt_r[5];
	wire brk_insvc = flt_r[6];
	wire energy_ok = flt_r[7];
	wire dt_permit = flt_r[8];
	wire dt_enable = flt_r[9];
	wire dar_done = flt_r[10];
	wire sync_a = flt_r[11];
	wire sync_b = flt_r[12];
	wire sys_ok = flt_r[13];
	wire man_inhibit = flt_r[14];

	// ************************************************
	// register file
	// ************************************************
	reg [1:0] mode_r; // operating mode
	reg dt_on_reset_r; // dead time also waits for protection reset
	reg clr_by_nonauto_r; // lockout cleared by non auto entry
	reg [2:0] shots_r; // main cycle shot count
	reg [2:0] sg_shots_r; // sensitive ground cycle shot count
	reg [4:0] blk_main_r; // per trip main inhibit mask
	reg [4:0] blk_sg_r; // per trip sensitive ground mask
	reg [TW*4-1:0] dead_lim_r; // dead times, shots one to four
	reg [TW-1:0] recl_lim_r;
	reg [TW-1:0] sys_lim_r;
	reg [TW-1:0] hlt_lim_r;
	reg lock_rst_cmd_r; // one-cycle lockout reset pulse
	reg [31:0] status_w; // live status word

	wire wr_en = psel && penable && pwrite;
	assign pready = 1'b1; // zero wait states

	// writes land in the access phase
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			mode_r <= `ARSEQ_CTRL_RST;
			dt_on_reset_r <= 1'b0;
			clr_by_nonauto_r <= 1'b0;
			shots_r <= `ARSEQ_SHOTS_RST;
			sg_shots_r <= `ARSEQ_SHOTS_RST;
			blk_main_r <= `ARSEQ_BLK_RST;
			blk_sg_r <= `ARSEQ_BLK_RST;
			dead_lim_r <= {4{`ARSEQ_DEAD_RST}};
			recl_lim_r <= `ARSEQ_RECLAIM_RST;
			sys_lim_r <= `ARSEQ_SYSWIN_RST;
			hlt_lim_r <= `ARSEQ_HEALTHY_RST;
			lock_rst_cmd_r <= 1'b0;
		end
		else if (clk_en)
		begin
			lock_rst_cmd_r <= wr_en && (paddr == `ARSEQ_CTRL_OFS)
				&& pwdata[`ARSEQ_LOCKOUT_RESET_BIT];
			if (wr_en)
			begin
				case (paddr)
					`ARSEQ_CTRL_OFS:
					begin
						mode_r <= pwdata[`ARSEQ_MODE_MSB:`ARSEQ_MODE_LSB];
						dt_on_reset_r <= pwdata[`ARSEQ_DT_ON_RESET_BIT];
						clr_by_nonauto_r <= pwdata[`ARSEQ_CLR_BY_NONAUTO_BIT];
					end
					`ARSEQ_SHOTS_OFS:
					begin
						shots_r <= pwdata[`ARSEQ_SHOTS_MSB:`ARSEQ_SHOTS_LSB];
						sg_shots_r <=
							pwdata[`ARSEQ_SGSHOTS_MSB:`ARSEQ_SGSHOTS_LSB];
					end
					`ARSEQ_BLOCK_OFS:
					begin
						blk_main_r <=
							pwdata[`ARSEQ_BLKMAIN_MSB:`ARSEQ_BLKMAIN_LSB];
						blk_sg_r <= pwdata[`ARSEQ_BLKSG_MSB:`ARSEQ_BLKSG_LSB];
					end
					`ARSEQ_DEAD1_OFS: dead_lim_r[TW-1:0] <= pwdata[TW-1:0];
					`ARSEQ_DEAD2_OFS:
						dead_lim_r[2*TW-1:TW] <= pwdata[TW-1:0];
					`ARSEQ_DEAD3_OFS:
						dead_lim_r[3*TW-1:2*TW] <= pwdata[TW-1:0];
					`ARSEQ_DEAD4_OFS:
						dead_lim_r[4*TW-1:3*TW] <= pwdata[TW-1:0];
					`ARSEQ_RECLAIM_OFS: recl_lim_r <= pwdata[TW-1:0];
					`ARSEQ_SYSWIN_OFS: sys_lim_r <= pwdata[TW-1:0];
					`ARSEQ_HEALTHY_OFS: hlt_lim_r <= pwdata[TW-1:0];
					default: ; // unmapped writes are dropped
				endcase
			end
		end
	end

	// read data is captured in setup so it comes from a flop
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata <= 32'h00000000;
			pslverr <= 1'b0;
		end
		else if (clk_en && psel && !penable)
		begin
			prdata <= 32'h00000000;
			pslverr <= 1'b0;
			case (paddr)
				`ARSEQ_CTRL_OFS:
					prdata[3:0] <= {clr_by_nonauto_r, dt_on_reset_r, mode_r};
				`ARSEQ_SHOTS_OFS: prdata[6:0] <= {sg_shots_r, 1'b0, shots_r};
				`ARSEQ_BLOCK_OFS:
					prdata[12:0] <= {blk_sg_r, 3'h0, blk_main_r};
				`ARSEQ_DEAD1_OFS: prdata[TW-1:0] <= dead_lim_r[TW-1:0];
				`ARSEQ_DEAD2_OFS: prdata[TW-1:0] <= dead_lim_r[2*TW-1:TW];
				`ARSEQ_DEAD3_OFS: prdata[TW-1:0] <= dead_lim_r[3*TW-1:2*TW];
				`ARSEQ_DEAD4_OFS: prdata[TW-1:0] <= dead_lim_r[4*TW-1:3*TW];
				`ARSEQ_RECLAIM_OFS: prdata[TW-1:0] <= recl_lim_r;
				`ARSEQ_SYSWIN_OFS: prdata[TW-1:0] <= sys_lim_r;
				`ARSEQ_HEALTHY_OFS: prdata[TW-1:0] <= hlt_lim_r;
				`ARSEQ_STATUS_OFS: prdata <= status_w;
				default: pslverr <= 1'b1; // unmapped address
			endcase
		end
	end

	// ************************************************
	// sequencer core
	// ************************************************
	reg [6:0] state_r;
	reg primed_r; // dead time primed within this cycle
	reg sg_cycle_r; // cycle started by sensitive ground trip
	reg brk_prev_r; // breaker closed, one cycle ago
	reg insvc_prev_r; // in-service qualifier before the trip
	reg lockout_r;
	wire [3:0] tmr_done;
	reg [3:0] tmr_run;
	reg [TW*4-1:0] tmr_lim;
	reg [TW-1:0] dead_sel;

	wire in_auto = (mode_r == `ARSEQ_MODE_AUTO);
	wire in_nonauto = (mode_r == `ARSEQ_MODE_NONAUTO);
	wire any_trip = p_trip || x_trip || sg_trip;
	wire any_start = p_start || x_start;
	wire prot_reset = !any_trip && !any_start;
	wire [2:0] shot_lim = sg_cycle_r ? sg_shots_r : shots_r;
	wire lock_reset = lock_rst_cmd_r
		|| (clr_by_nonauto_r && in_nonauto);
	wire checks_ok = synchronism_ok_flag || system_checks_pass_flag;

	assign reclose_enabled_flag = in_auto;
	assign reclose_cycle_active = !state_r[0] && !state_r[6];
	assign reclose_checks = primed_r;
	assign dead_time_running = primed_r && dt_enable;
	assign reset_lockout_ind = clr_by_nonauto_r && in_nonauto;
	assign reclose_lockout_alarm = lockout_r;

	// decoded counter flags, one per value zero to four
	generate
		for (gi = 0; gi < 5; gi = gi + 1)
		begin : g_cnt
			assign shot_count_is[gi] = (shot_counter == gi);
		end
	endgenerate

	// dead time for the current shot, one to four
	always @*
	begin
		case (shot_counter)
			3'h2: dead_sel = dead_lim_r[2*TW-1:TW];
			3'h3: dead_sel = dead_lim_r[3*TW-1:2*TW];
			3'h4: dead_sel = dead_lim_r[4*TW-1:3*TW];
			default: dead_sel = dead_lim_r[TW-1:0];
		endcase
	end

	// which timers run in which state
	always @*
	begin
		tmr_lim = {hlt_lim_r, sys_lim_r, recl_lim_r, dead_sel};
		tmr_run = 4'h0;
		// enable low stops and clears the dead timer
		tmr_run[T_DEAD] = state_r[2] && dead_time_running
			&& !brk_closed;
		tmr_run[T_RECL] = state_r[5];
		tmr_run[T_SYS] = state_r[3];
		tmr_run[T_HLT] = state_r[3];
	end

	generate
		for (gi = 0; gi < 4; gi = gi + 1)
		begin : g_tmr
			arseq_timer #(
				.TW(TW)
			) u_tmr (
				.pclk(pclk),
				.presetn(presetn),
				.clk_en(clk_en),
				.tick(tick),
				.run(tmr_run[gi]),
				.limit(tmr_lim[gi*TW+TW-1:gi*TW]),
				.done(tmr_done[gi])
			);
		end
	endgenerate

	// main cycle, one transition per enabled clock
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_r <= S_IDLE;
			shot_counter <= 3'h0;
			primed_r <= 1'b0;
			sg_cycle_r <= 1'b0;
			brk_prev_r <= 1'b0;
			insvc_prev_r <= 1'b0;
			lockout_r <= 1'b0;
			successful_reclose <= 1'b0;
			dead_time_done <= 1'b0;
			auto_close <= 1'b0;
			protection_lockout <= 1'b0;
			voltage_check_fail_alarm <= 1'b0;
			breaker_energy_fail_alarm <= 1'b0;
			reclose_cycle_active_secondary <= 1'b0;
		end
		else if (clk_en)
		begin
			brk_prev_r <= brk_closed;
			insvc_prev_r <= brk_insvc;
			// next breaker trip clears success
			if (brk_prev_r && !brk_closed)
				successful_reclose <= 1'b0;
			// delayed reclose done drops the secondary early
			if (dar_done)
				reclose_cycle_active_secondary <= 1'b0;
			case (state_r)
				S_IDLE:
				begin
					if (any_trip || any_start)
					begin
						// in-service level is taken before the trip
						if (!in_auto || man_inhibit)
						begin
							if (any_trip && insvc_prev_r)
							begin
								state_r <= S_LOCK;
								lockout_r <= 1'b1;
								protection_lockout <= 1'b1;
							end
						end
						else if (insvc_prev_r)
						begin
							state_r <= S_PRIME;
							shot_counter <= 3'h1;
							sg_cycle_r <= sg_trip && !p_trip && !x_trip;
							reclose_cycle_active_secondary <= 1'b1;
							dead_time_done <= 1'b0;
							successful_reclose <= 1'b0;
						end
					end
				end
				S_PRIME:
				begin
					// permit matters only until primed
					if (!brk_closed && dt_permit
						&& (prot_reset || !dt_on_reset_r))
					begin
						primed_r <= 1'b1;
						state_r <= S_DEAD;
					end
				end
				S_DEAD:
				begin
					if (any_trip)
						dead_time_done <= 1'b0;
					else if (tmr_done[T_DEAD])
					begin
						dead_time_done <= 1'b1;
						state_r <= S_CHECK;
					end
				end
				S_CHECK:
				begin
					if (any_trip)
						dead_time_done <= 1'b0;
					if (checks_ok && energy_ok)
					begin
						auto_close <= 1'b1;
						state_r <= S_CLOSE;
					end
					else if (!checks_ok && tmr_done[T_SYS])
					begin
						voltage_check_fail_alarm <= 1'b1;
						// secondary must drop with the main active
						reclose_cycle_active_secondary <= 1'b0;
						lockout_r <= 1'b1;
						state_r <= S_LOCK;
					end
					else if (!energy_ok && tmr_done[T_HLT])
					begin
						breaker_energy_fail_alarm <= 1'b1;
						reclose_cycle_active_secondary <= 1'b0;
						lockout_r <= 1'b1;
						state_r <= S_LOCK;
					end
				end
				S_CLOSE:
				begin
					// close request held until breaker is closed
					if (brk_closed)
					begin
						auto_close <= 1'b0;
						primed_r <= 1'b0;
						state_r <= S_RECL;
					end
				end
				S_RECL:
				begin
					if (any_trip)
					begin
						dead_time_done <= 1'b0;
						if (shot_counter < shot_lim)
						begin
							shot_counter <= shot_counter + 3'h1;
							state_r <= S_PRIME;
						end
						else
						begin
							// no shots left, the cycle ends here
							reclose_cycle_active_secondary <= 1'b0;
							lockout_r <= 1'b1;
							state_r <= S_LOCK;
						end
					end
					else if (tmr_done[T_RECL])
					begin
						// reclaim expired without a fault
						successful_reclose <= 1'b1;
						shot_counter <= 3'h0;
						dead_time_done <= 1'b0;
						reclose_cycle_active_secondary <= 1'b0;
						state_r <= S_IDLE;
					end
				end
				S_LOCK:
				begin
					// no reclose attempt is made from here
					shot_counter <= 3'h0;
					primed_r <= 1'b0;
					auto_close <= 1'b0;
					dead_time_done <= 1'b0;
					reclose_cycle_active_secondary <= 1'b0;
					if (lock_reset)
					begin
						lockout_r <= 1'b0;
						protection_lockout <= 1'b0;
						voltage_check_fail_alarm <= 1'b0;
						breaker_energy_fail_alarm <= 1'b0;
						successful_reclose <= 1'b0;
						state_r <= S_IDLE;
					end
				end
				default: state_r <= S_IDLE;
			endcase
		end
	end

	// ************************************************
	// qualifier flags and protection inhibits
	// ************************************************
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			synchronism_ok_flag <= 1'b0;
			system_checks_pass_flag <= 1'b0;
			inhibit_main_instant_stages <= 1'b0;
			inhibit_sensitive_ground_stages <= 1'b0;
		end
		else if (clk_en)
		begin
			synchronism_ok_flag <= sync_a || sync_b;
			system_checks_pass_flag <= sync_a || sync_b || sys_ok;
			// mask bit n-1 covers trip n; counter holds trips so far
			inhibit_main_instant_stages <= reclose_cycle_active
				&& (shot_counter != 3'h0) && (shot_counter < 3'h6)
				&& blk_main_r[shot_counter - 3'h1];
			inhibit_sensitive_ground_stages <= reclose_cycle_active
				&& (shot_counter != 3'h0) && (shot_counter < 3'h6)
				&& blk_sg_r[shot_counter - 3'h1];
		end
	end

	// live status word for software
	always @*
	begin
		status_w = 32'h00000000;
		status_w[13:0] = {in_auto, primed_r, auto_close, dead_time_done,
			protection_lockout, breaker_energy_fail_alarm,
			voltage_check_fail_alarm, lockout_r, successful_reclose,
			shot_counter, reclose_cycle_active_secondary,
			reclose_cycle_active};
	end
endmodule
`default_nettype wire

/* hdl/arseq_defines.vh */
`ifndef ARSEQ_DEFINES_VH
`define ARSEQ_DEFINES_VH
// ************************************************
// register byte offsets
// ************************************************
`define ARSEQ_CTRL_OFS 8'h00
`define ARSEQ_SHOTS_OFS 8'h04
`define ARSEQ_BLOCK_OFS 8'h08
`define ARSEQ_DEAD1_OFS 8'h10
`define ARSEQ_DEAD2_OFS 8'h14
`define ARSEQ_DEAD3_OFS 8'h18
`define ARSEQ_DEAD4_OFS 8'h1C
`define ARSEQ_RECLAIM_OFS 8'h20
`define ARSEQ_SYSWIN_OFS 8'h24
`define ARSEQ_HEALTHY_OFS 8'h28
`define ARSEQ_STATUS_OFS 8'h2C
// ************************************************
// field positions
// ************************************************
`define ARSEQ_MODE_LSB 0
`define ARSEQ_MODE_MSB 1
`define ARSEQ_DT_ON_RESET_BIT 2
`define ARSEQ_CLR_BY_NONAUTO_BIT 3
`define ARSEQ_LOCKOUT_RESET_BIT 4
`define ARSEQ_SHOTS_LSB 0
`define ARSEQ_SHOTS_MSB 2
`define ARSEQ_SGSHOTS_LSB 4
`define ARSEQ_SGSHOTS_MSB 6
`define ARSEQ_BLKMAIN_LSB 0
`define ARSEQ_BLKMAIN_MSB 4
`define ARSEQ_BLKSG_LSB 8
`define ARSEQ_BLKSG_MSB 12
// ************************************************
// mode codes
// ************************************************
`define ARSEQ_MODE_NONAUTO 2'h0
`define ARSEQ_MODE_AUTO 2'h1
`define ARSEQ_MODE_LIVELINE 2'h2
// ************************************************
// reset values and timer width
// ************************************************
`define ARSEQ_TW 16
`define ARSEQ_CTRL_RST 2'h0
`define ARSEQ_SHOTS_RST 3'h1
`define ARSEQ_BLK_RST 5'h00
`define ARSEQ_DEAD_RST 16'h000A
`define ARSEQ_RECLAIM_RST 16'h0064
`define ARSEQ_SYSWIN_RST 16'h0032
`define ARSEQ_HEALTHY_RST 16'h0032
`endif

/* hdl/arseq_timer.v */
`timescale 1ns/1ps
`default_nettype none
// ************************************************
// tick based interval timer
// ************************************************
module arseq_timer #(
	parameter TW = 16
)(
	input wire pclk,
	input wire presetn,
	input wire clk_en,
	input wire tick,
	input wire run,
	input wire [TW-1:0] limit,
	output wire done
);
	reg [TW-1:0] count_r; // elapsed ticks

	// stopping the timer clears it, so a restart times from zero
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			count_r <= {TW{1'b0}};
		else if (clk_en)
		begin
			if (!run)
				count_r <= {TW{1'b0}};
			else if (tick && (count_r < limit))
				count_r <= count_r + {{(TW-1){1'b0}}, 1'b1};
		end
	end

	// expiry is checked against the loaded setting
	assign done = run && (count_r >= limit);
endmodule
`default_nettype wire

/* verif/arseq_sva.sv */
`timescale 1ns/1ps
`default_nettype none
// *****
// port checks of the reclose sequencer
// *****
module arseq_sva(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic reclose_cycle_active,
	input wire logic reclose_cycle_active_secondary,
	input wire logic [2:0] shot_counter,
	input wire logic [4:0] shot_count_is,
	input wire logic reclose_checks,
	input wire logic dead_time_running,
	input wire logic dead_time_done,
	input wire logic auto_close,
	input wire logic reclose_lockout_alarm
);
	// one domain: bus clock and its reset
	default clocking @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	// a 5 bit shift gives zero past four, as the flags must
	property p_decode;
		shot_count_is == (5'h01 << shot_counter);
	endproperty
	a_decode: assert property (p_decode) else $error("bad decode");
	property p_second;
		reclose_cycle_active_secondary |-> reclose_cycle_active;
	endproperty
	a_second: assert property (p_second) else $error("bad second");
	property p_start;
		$rose(reclose_cycle_active) |-> reclose_cycle_active_secondary;
	endproperty
	a_start: assert property (p_start) else $error("bad start");
	property p_run;
		dead_time_running |-> reclose_checks;
	endproperty
	a_run: assert property (p_run) else $error("bad run");
	property p_clear;
		$fell(reclose_cycle_active) |-> ##[0:1] shot_counter == 3'h0;
	endproperty
	a_clear: assert property (p_clear) else $error("bad clear");
	// the counter only steps by one or returns to zero
	property p_step;
		$changed(shot_counter) |-> (shot_counter == 3'h0) ||
			(shot_counter == $past(shot_counter) + 3'h1);
	endproperty
	a_step: assert property (p_step) else $error("bad step");
	property p_lock;
		reclose_lockout_alarm |-> !reclose_cycle_active && !auto_close;
	endproperty
	a_lock: assert property (p_lock) else $error("bad lock");
	property p_close;
		$rose(auto_close) |-> dead_time_done && reclose_cycle_active;
	endproperty
	a_close: assert property (p_close) else $error("bad close");
endmodule
bind arseq_sequencer arseq_sva u_sva (.*);
`default_nettype wire

/* verif/arseq_breaker.sv */
`timescale 1ns/1ps
`default_nettype none
// *****
// breaker: contacts move DLY+1 cycles after a command
// *****
module arseq_breaker #(
	parameter DLY = 6
)(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic trip,
	input wire logic close_req,
	output logic closed
);
	logic [3:0] cnt_r; // travel time so far
	// travel delay keeps in service high while the trip is seen
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			closed <= 1'b1;
			cnt_r <= 4'h0;
		end
		else if (closed ? trip : close_req && !trip)
		begin
			cnt_r <= cnt_r + 4'h1;
			if (cnt_r == 4'(DLY))
			begin
				closed <= !closed;
				cnt_r <= 4'h0;
			end
		end
		else
			cnt_r <= 4'h0;
	end
endmodule
`default_nettype wire

/* verif/autoreclose_sequencer_test.sv */
`timescale 1ns/1ps
`default_nettype none
`include "arseq_defines.vh"
// *****
// reclose sequencer bench
// *****
module autoreclose_sequencer_test;
	logic pclk, pready, pslverr, sec, act, suc, ena, inh, dtr, ac;
	logic pl, rli, va, ea, lo, bc, sc, so, isg, dtd, rc;
	logic presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic trip = 1'b0, ext = 1'b0, dd = 1'b0, mci = 1'b0, mc = 1'b0;
	logic hok = 1'b1, sa = 1'b1, sok = 1'b0, en = 1'b1, perm = 1'b1;
	logic tick = 1'b0;
	logic [1:0] tc = 2'h0;
	logic [2:0] shot_counter;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h00000000, prdata;
	logic [13:0] mon;
	int n_mismatch = 0, n_compared = 0;
	// outputs watched by the wait task, by index
	assign mon = {sc, dtr, rli, inh, ena, bc, lo, ea, va, pl, suc, act, ac, sec};
	arseq_sequencer DUT (.*, .clk_en(1'b1), .prot_trip_in(trip),
		.prot_start_in(1'b0), .ext_trip_in(ext), .ext_start_in(ext),
		.sensitive_ground_fault_trip_in(1'b0), .breaker_closed_in(bc),
		.breaker_in_service_in(bc), .breaker_energy_ok_in(hok),
		.dead_time_start_permit_in(perm), .dead_time_enable_in(en),
		.delayed_reclose_done_in(dd), .sync_check_a_in(sa),
		.sync_check_b_in(1'b0), .system_check_ok_in(sok),
		.manual_close_inhibit_in(mci), .reclose_cycle_active(act),
		.reclose_cycle_active_secondary(sec), .shot_count_is(),
		.successful_reclose(suc), .reclose_enabled_flag(ena),
		.inhibit_main_instant_stages(inh), .reclose_checks(rc),
		.inhibit_sensitive_ground_stages(isg), .dead_time_done(dtd),
		.dead_time_running(dtr), .synchronism_ok_flag(so),
		.system_checks_pass_flag(sc), .auto_close(ac),
		.protection_lockout(pl), .reset_lockout_ind(rli),
		.voltage_check_fail_alarm(va), .breaker_energy_fail_alarm(ea),
		.reclose_lockout_alarm(lo));
	arseq_breaker #(.DLY(6)) u_brk (.pclk(pclk), .presetn(presetn),
		.trip(trip | ext), .close_req(ac | mc), .closed(bc));
	initial
	begin
		pclk = 1'b0;
		forever
			#10 pclk = ~pclk;
	end
	// a tick every fourth cycle keeps the timers short
	always @(posedge pclk)
	begin
		tc <= tc + 2'h1;
		tick <= (tc == 2'h3);
	end
	task complete_run;
		if (n_mismatch == 0 && n_compared > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task chk(input logic [31:0] g, input logic [31:0] x);
		n_compared++;
		if (g !== x)
		begin
			n_mismatch++;
			$display("BAD %0t got %h exp %h", $time, g, x);
		end
	endtask
	// one bus transfer: setup, then access until ready
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		int i;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		for (i = 0; i < 99; i++)
		begin
			@(posedge pclk);
			if (pready === 1'b1)
				break;
		end
		chk(pready, 1'b1);
		if (pready !== 1'b1)
			complete_run();
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task rd(input logic [7:0] a, input logic [31:0] x, input logic xe);
		logic [31:0] r;
		logic e;
		apb(1'b0, a, 32'h00000000, r, e);
		chk(r, x);
		chk(e, xe);
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic e;
		apb(1'b1, a, d, r, e);
	endtask
	// sampled on the falling edge, where outputs have settled
	task wt(input int k, input logic v);
		int i;
		for (i = 0; i < 999; i++)
		begin
			@(negedge pclk);
			if (mon[k] === v)
				break;
		end
		chk(mon[k], v);
		if (mon[k] !== v)
			complete_run();
	endtask
	// trip held until the contacts part, then protection resets
	task fault(input logic x);
		@(posedge pclk);
		trip <= !x;
		ext <= x;
		wt(8, 1'b0);
		@(posedge pclk);
		trip <= 1'b0;
		ext <= 1'b0;
	endtask
	task reclose;
		wt(1, 1'b1);
		chk(dtd, 1'b1);
		wt(8, 1'b1);
		wt(1, 1'b0);
	endtask
	task unlock(input int k);
		wr(`ARSEQ_CTRL_OFS, 32'h00000011);
		wt(k, 1'b0);
		wt(7, 1'b0);
		@(posedge pclk);
		mc <= 1'b1;
		wt(8, 1'b1);
		@(posedge pclk);
		mc <= 1'b0;
	endtask
	task t_regs;
		rd(`ARSEQ_CTRL_OFS, 32'h00000000, 1'b0);
		rd(`ARSEQ_SHOTS_OFS, 32'h00000011, 1'b0);
		rd(`ARSEQ_DEAD4_OFS, 32'h0000000A, 1'b0);
		rd(`ARSEQ_SYSWIN_OFS, 32'h00000032, 1'b0);
		rd(8'h0C, 32'h00000000, 1'b1);
	endtask
	task t_mode;
		wr(`ARSEQ_CTRL_OFS, 32'h00000008);
		wt(11, 1'b1);
		wr(`ARSEQ_CTRL_OFS, 32'h0000000A);
		wt(11, 1'b0);
		wt(9, 1'b0);
		wr(`ARSEQ_CTRL_OFS, 32'h00000001);
		wt(9, 1'b1);
		wr(`ARSEQ_DEAD1_OFS, 32'h00000003);
		wr(`ARSEQ_DEAD2_OFS, 32'h00000003);
		wr(`ARSEQ_RECLAIM_OFS, 32'h00000006);
		wr(`ARSEQ_SYSWIN_OFS, 32'h00000003);
		wr(`ARSEQ_HEALTHY_OFS, 32'h00000005);
		wr(`ARSEQ_SHOTS_OFS, 32'h00000002);
		wr(`ARSEQ_BLOCK_OFS, 32'h00000101);
	endtask
	task t_cycle;
		@(posedge pclk);
		perm <= 1'b0;
		fault(1'b0);
		wt(2, 1'b1);
		wt(0, 1'b1);
		wt(10, 1'b1);
		chk(isg, 1'b1);
		chk(shot_counter, 3'h1);
		repeat (20) @(posedge pclk);
		chk(rc, 1'b0);
		perm <= 1'b1;
		wt(12, 1'b1);
		chk(rc, 1'b1);
		@(posedge pclk);
		perm <= 1'b0;
		en <= 1'b0;
		repeat (30) @(posedge pclk);
		chk(ac, 1'b0);
		en <= 1'b1;
		wt(12, 1'b1);
		@(posedge pclk);
		perm <= 1'b1;
		reclose();
		fault(1'b0);
		wt(10, 1'b0);
		chk(isg, 1'b0);
		chk(shot_counter, 3'h2);
		@(posedge pclk);
		dd <= 1'b1;
		wt(0, 1'b0);
		chk(act, 1'b1);
		@(posedge pclk);
		dd <= 1'b0;
		reclose();
		wt(2, 1'b0);
		chk(dtd, 1'b0);
		wt(3, 1'b1);
		chk(shot_counter, 3'h0);
		fault(1'b1);
		wt(3, 1'b0);
		reclose();
		fault(1'b0);
		reclose();
		fault(1'b0);
		wt(7, 1'b1);
		unlock(7);
	endtask
	task t_alarm;
		@(posedge pclk);
		hok <= 1'b0;
		fault(1'b0);
		wt(6, 1'b1);
		unlock(6);
		@(posedge pclk);
		hok <= 1'b1;
		sa <= 1'b0;
		wt(13, 1'b0);
		chk(so, 1'b0);
		fault(1'b0);
		wt(5, 1'b1);
		unlock(5);
		@(posedge pclk);
		sok <= 1'b1;
		wt(13, 1'b1);
		chk(so, 1'b0);
	endtask
	task t_plock;
		@(posedge pclk);
		mci <= 1'b1;
		fault(1'b0);
		wt(4, 1'b1);
		@(posedge pclk);
		mci <= 1'b0;
		unlock(4);
		wr(`ARSEQ_CTRL_OFS, 32'h00000000);
		fault(1'b0);
		wt(4, 1'b1);
	endtask
	initial
	begin
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		t_regs();
		t_mode();
		t_cycle();
		t_alarm();
		t_plock();
		complete_run();
	end
endmodule
`default_nettype wire
